// ==== bench/mibp_addon_model.sv ====
// add-on side master and byte port driver
`timescale 1ns/1ns
module mibp_addon_model (
  // add-on bus
  output logic        aclk,
  output logic        sel,
  output logic        wr,
  output logic        rd,
  output logic [1:0]  adr,
  output logic [3:0]  be,
  output logic [31:0] dq,
  // byte port
  output logic        load_n,
  output logic [7:0]  port_in,
  input  wire  [7:0]  port_out,
  input  wire         oe_n
);
  logic [7:0] md_drv;
  logic       md_en;
  // wire level: device when its enable is low, else model or a changing pattern
  assign port_in = oe_n ? md_drv : port_out;
  initial begin
    {sel, wr, rd, adr, be, dq, md_drv, md_en} = '0;
    load_n = 1'b1;
    aclk = 1'b0;
    #7;
    forever #160 aclk = ~aclk;
  end
  // released lines do not keep their last value
  always @(posedge aclk) begin
    if (!wr)
      dq <= ~dq;
    if (!md_en)
      md_drv <= ~md_drv;
  end
  task automatic acc(input logic w, input logic [1:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge aclk);
    sel <= 1'b1;
    wr <= w;
    rd <= ~w;
    adr <= a;
    be <= b;
    dq <= d;
    @(negedge aclk);
    sel <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic load(input logic [7:0] v);
    @(negedge aclk);
    load_n <= 1'b0;
    // one add-on cycle with nobody driving before the data comes
    @(negedge aclk);
    md_en <= 1'b1;
    md_drv <= v;
    @(negedge aclk);
    load_n <= 1'b1;
    md_en <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// ==== bench/mibp_core_sva.sv ====
// assertion checker for the mailbox interrupt block
`timescale 1ns/1ns
`include "mibp_defines.vh"
module mibp_core_sva (
  // clock, reset and bus
  input wire        CLK,
  input wire        RESET,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire        WB_ACK_O,
  // interrupts and byte port
  input wire        INTA_N,
  input wire        ADDON_CLK,
  input wire        ADDON_IRQ_N,
  input wire        PORT_LOAD_N,
  input wire        PORT_DIR_STRAP,
  input wire [7:0]  MAILBOX_BYTE_PORT_OUT,
  input wire        MAILBOX_BYTE_PORT_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_int_clear;
    WB_ACK_O && WB_WE_I && WB_ADR_I == `MIBP_ADR_PCI_INT_CTRL && WB_SEL_I[2] && WB_DAT_I[17:16] == 2'b11;
  endsequence
  sequence s_byte3_write;
    WB_ACK_O && WB_WE_I && WB_ADR_I == `MIBP_ADR_PCI_OUT_MBOX && WB_SEL_I[3];
  endsequence
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
    else $error("request not answered in one cycle");
  chk_int_release: assert property (s_int_clear |=> INTA_N)
    else $error("pci interrupt not released after clear");
  chk_port_follow: assert property (s_byte3_write |=> MAILBOX_BYTE_PORT_OUT == $past(WB_DAT_I[31:24]))
    else $error("byte port output does not follow byte 3 write");
  chk_strap_input: assert property (PORT_DIR_STRAP [*6] |-> MAILBOX_BYTE_PORT_OE_N)
    else $error("byte port driven in input-only mode");
  chk_load_release: assert property (!PORT_LOAD_N [*6] |-> MAILBOX_BYTE_PORT_OE_N)
    else $error("byte port driven while load strobe low");
  chk_port_drive: assert property ((!PORT_DIR_STRAP && PORT_LOAD_N) [*6] |-> !MAILBOX_BYTE_PORT_OE_N)
    else $error("byte port not driven in bidirectional mode");
  chk_irq_on_edge: assert property ($changed(ADDON_IRQ_N) |-> $past(ADDON_CLK))
    else $error("add-on interrupt changed away from add-on edge");
  chk_inta_addon: assert property ($fell(INTA_N) |-> $past(ADDON_CLK, 2))
    else $error("pci interrupt raised away from add-on edge");
endmodule

bind mibp_core mibp_core_sva mibp_core_sva_inst (
  .CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .INTA_N(INTA_N), .ADDON_CLK(ADDON_CLK), .ADDON_IRQ_N(ADDON_IRQ_N), .PORT_LOAD_N(PORT_LOAD_N),
  .PORT_DIR_STRAP(PORT_DIR_STRAP), .MAILBOX_BYTE_PORT_OUT(MAILBOX_BYTE_PORT_OUT),
  .MAILBOX_BYTE_PORT_OE_N(MAILBOX_BYTE_PORT_OE_N));

// ==== bench/mibp_core_test.sv ====
// self-checking bench for the mailbox interrupt block
`timescale 1ns/1ns
`include "mibp_defines.vh"
module mibp_core_test;
  logic        clk, reset, cyc, stb, we, ack, dir, inta_n, irq_n, oe_n;
  logic        aclk, asel, awr, ard, load_n, wide;
  logic [1:0]  aadr;
  logic [3:0]  sel, abe;
  logic [7:0]  adr, pin, pout;
  logic [31:0] dat_w, dat_r, adq, addon_dq_out, rd_v;
  int          num_errors, samples_checked;

  mibp_core mibp_core_inst (
    .CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .INTA_N(inta_n),
    .ADDON_CLK(aclk), .ADDON_SEL(asel), .ADDON_WR(awr), .ADDON_RD(ard), .ADDON_ADR(aadr),
    .ADDON_BYTE_ENABLE(abe), .ADDON_DQ_IN(adq), .ADDON_DQ_OUT(addon_dq_out), .ADDON_IRQ_N(irq_n),
    .PORT_LOAD_N(load_n), .MAILBOX_BYTE_PORT_IN(pin), .MAILBOX_BYTE_PORT_OUT(pout),
    .MAILBOX_BYTE_PORT_OE_N(oe_n), .PORT_DIR_STRAP(dir), .ADDON_WIDTH_STRAP(wide));
  mibp_addon_model mibp_addon_model_inst (
    .aclk(aclk), .sel(asel), .wr(awr), .rd(ard), .adr(aadr), .be(abe), .dq(adq),
    .load_n(load_n), .port_in(pin), .port_out(pout), .oe_n(oe_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for an interrupt level; which 0 is the pci line
  task automatic lvl(input string what, input logic exp, input int which);
    int n;
    n = 0;
    while ((which ? irq_n : inta_n) !== exp && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp(what, exp, which ? irq_n : inta_n);
    if (n == 400)
      report_and_stop();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd_v = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] exp, input string what);
    wb(1'b0, a, s, 32'h0000_0000);
    cmp(what, exp, rd_v);
  endtask
  task automatic ard_chk(input logic [1:0] a, input logic [31:0] exp, input string what);
    mibp_addon_model_inst.acc(1'b0, a, 4'hF, 32'h0000_0000);
    cmp(what, exp, addon_dq_out);
  endtask

  initial begin
    {cyc, stb, we, adr, sel, dat_w, dir, wide, num_errors, samples_checked} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`MIBP_ADR_PCI_INT_CTRL, 4'hF, 32'h0000_0000, "pci ctrl reset");
    rd(`MIBP_ADR_PCI_FLAGS, 4'hF, 32'h0000_0000, "pci flags reset");
    rd(8'h40, 4'hF, 32'h0000_0000, "unmapped read");
    wb(1'b1, `MIBP_ADR_PCI_INT_CTRL, 4'h3, 32'h0000_FFFF);
    rd(`MIBP_ADR_PCI_INT_CTRL, 4'hF, 32'h0000_1313, "pci ctrl mask");
    $display("test reset and control done");

    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_INT_CTRL, 4'h3, 32'h0000_1313);
    wb(1'b1, `MIBP_ADR_PCI_OUT_MBOX, 4'h8, 32'hA500_0000);
    lvl("addon irq in full", 1'b0, 1);
    rd(`MIBP_ADR_PCI_FLAGS, 4'hF, 32'h0000_8000, "pci flags out full");
    cmp("port out", 32'h0000_00A5, pout);
    ard_chk(`MIBP_AADR_INT_CTRL, 32'h0001_1313, "addon ctrl");
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_INT_CTRL, 4'h7, 32'h0001_1313);
    lvl("addon irq clear", 1'b1, 1);
    ard_chk(`MIBP_AADR_IN_MBOX, 32'hA500_0000, "addon in mbox");
    lvl("pci out empty", 1'b0, 0);
    rd(`MIBP_ADR_PCI_INT_CTRL, 4'hF, 32'h0081_1313, "pci ctrl pending");
    rd(`MIBP_ADR_PCI_FLAGS, 4'hF, 32'h0000_0000, "pci flags emptied");
    wb(1'b1, `MIBP_ADR_PCI_INT_CTRL, 4'h7, 32'h0003_1313);
    lvl("pci irq clear", 1'b1, 0);
    $display("test pci to addon done");

    cmp("port enable bidir", 32'h0000_0000, oe_n);
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_OUT_MBOX, 4'h1, 32'h0000_0011);
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_OUT_MBOX, 4'h1, 32'h0000_0022);
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_OUT_MBOX, 4'h8, 32'h3300_0000);
    lvl("pci in full", 1'b0, 0);
    mibp_addon_model_inst.load(8'h77);
    rd(`MIBP_ADR_PCI_IN_MBOX, 4'h9, 32'h7700_0022, "pci in mbox");
    lvl("addon out empty", 1'b0, 1);
    rd(`MIBP_ADR_PCI_IN_MBOX, 4'h9, 32'h7700_0022, "pci in stale");
    rd(`MIBP_ADR_PCI_FLAGS, 4'hF, 32'h0000_0000, "pci flags read");
    wb(1'b1, `MIBP_ADR_PCI_INT_CTRL, 4'h7, 32'h0003_1313);
    lvl("pci irq clear 2", 1'b1, 0);
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_INT_CTRL, 4'h7, 32'h0002_1313);
    lvl("addon irq clear 2", 1'b1, 1);
    $display("test bidirectional port done");

    dir <= 1'b1;
    repeat (6) @(posedge clk);
    mibp_addon_model_inst.load(8'h3C);
    lvl("pci irq from load", 1'b0, 0);
    cmp("port enable input", 32'h0000_0001, oe_n);
    rd(`MIBP_ADR_PCI_IN_MBOX, 4'h8, 32'h3C00_0022, "pci in load");
    wb(1'b1, `MIBP_ADR_PCI_INT_CTRL, 4'h7, 32'h0003_1313);
    lvl("pci irq clear 3", 1'b1, 0);
    $display("test input-only port done");

    wide <= 1'b1;
    repeat (6) @(posedge clk);
    mibp_addon_model_inst.acc(1'b1, `MIBP_AADR_OUT_MBOX, 4'h9, 32'h0000_0055);
    rd(`MIBP_ADR_PCI_IN_MBOX, 4'h4, 32'h3C55_0022, "pci in 16-bit");
    ard_chk(`MIBP_AADR_OUT_MBOX, 32'h0000_3C55, "addon 16-bit upper");
    $display("test 16-bit bus done");
    report_and_stop();
  end
endmodule

// ==== hw/mibp_core.v ====
// mailbox pair with interrupt generation and the byte-3 load port
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Functional notes
// RULE1: enabled incoming byte becoming full raises that side's interrupt.
// RULE2: enabled outgoing byte emptied by the far side's read raises that side's interrupt.
// RULE3: pci and add-on sides have separate enables and byte selects.
// RULE4: eight-line byte port maps lines 0..7 onto add-on outgoing bits 24..31.
// RULE5: direction strap high means input only, low means bidirectional.
// RULE6: load strobe low at add-on clock captures port into add-on outgoing byte 3.
// RULE7: port capture can raise the pci interrupt when enabled.
// RULE8: add-on outgoing byte 3 holds the most recent write from either path.
// RULE9: bidirectional, strobe high: port drives pci outgoing byte 3, follows pci writes.
// RULE10: bidirectional, strobe low: port drivers released.
// RULE11: external party inserts a turnaround before driving the port.
// RULE12: burst to mailbox ends after one data phase.
// RULE13: writing a full outgoing byte overwrites silently.
// RULE14: reading an empty incoming byte returns stale contents.
// RULE15: pci interrupt asserts at pci edge after add-on write completes.
// RULE16: pci interrupt asserts at pci edge after add-on read completes.
// RULE17: pci interrupt deasserts one pci clock after write-one clear.
// RULE18: add-on interrupt asserts at add-on edge after pci write completes.
// RULE19: add-on interrupt asserts at add-on edge after pci read completes.
// RULE20: add-on interrupt deasserts one add-on clock after write-one clear.
// RULE21: 8-bit add-on master uses exactly one byte enable per access; the core writes every enabled byte and the bench uses several.
// RULE22: 16-bit strap makes byte enable 3 act as address bit 1.
// RULE23: outgoing write sets flags per byte enable; incoming read clears them both sides.
// RULE24: pci control bit 4 enables outgoing-empty, bits 1:0 pick its byte.
// RULE25: pci control bit 12 enables incoming-full, bits 9:8 pick its byte.
// RULE26: cross-domain events raise exactly one request in the destination domain.
`include "mibp_defines.vh"

module mibp_core (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // wishbone slave, pci-side registers
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // pci interrupt
  output reg         INTA_N,
  // add-on register port, on the add-on clock
  input  wire        ADDON_CLK,
  input  wire        ADDON_SEL,
  input  wire        ADDON_WR,
  input  wire        ADDON_RD,
  input  wire [1:0]  ADDON_ADR,
  input  wire [3:0]  ADDON_BYTE_ENABLE,
  input  wire [31:0] ADDON_DQ_IN,
  output reg  [31:0] ADDON_DQ_OUT,
  output reg         ADDON_IRQ_N,
  // byte port and straps
  input  wire        PORT_LOAD_N,
  input  wire [7:0]  MAILBOX_BYTE_PORT_IN,
  output reg  [7:0]  MAILBOX_BYTE_PORT_OUT,
  output reg         MAILBOX_BYTE_PORT_OE_N,
  input  wire        PORT_DIR_STRAP,
  input  wire        ADDON_WIDTH_STRAP
);

  // width of the sampled add-on bundle
  localparam SW = 53;

  // all foreign inputs pass two flops; data is only used at a detected add-on
  // edge, by which time the master's data has long settled
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;
  reg           aclk_prev_q;

  reg  [31:0] pci_out_mailbox_q;
  reg  [31:0] addon_out_mailbox_q;
  reg  [3:0]  pout_full_q;
  reg  [3:0]  aout_full_q;
  reg  [31:0] pci_int_ctrl_status_q;
  reg  [31:0] addon_int_ctrl_status_q;
  reg         pin_int_q;
  reg         pout_int_q;
  reg         ain_int_q;
  reg         aout_int_q;

  reg  [31:0] pci_out_mailbox_d;
  reg  [31:0] addon_out_mailbox_d;
  reg  [3:0]  pout_full_d;
  reg  [3:0]  aout_full_d;
  reg  [31:0] pci_int_ctrl_status_d;
  reg  [31:0] addon_int_ctrl_status_d;
  reg         pin_int_d;
  reg         pout_int_d;
  reg         ain_int_d;
  reg         aout_int_d;
  reg         ev_pin;
  reg         ev_pout;
  reg         ev_ain;
  reg         ev_aout;
  reg  [31:0] wb_rdata;
  reg  [31:0] a_rdata;
  integer     i;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_q     <= {SW{1'b0}};
      sync2_q     <= {SW{1'b0}};
      aclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {ADDON_CLK,
                      ADDON_SEL,
                      ADDON_WR,
                      ADDON_RD,
                      ADDON_ADR,
                      ADDON_BYTE_ENABLE,
                      ADDON_DQ_IN,
                      PORT_LOAD_N,
                      MAILBOX_BYTE_PORT_IN,
                      PORT_DIR_STRAP,
                      ADDON_WIDTH_STRAP};
      sync2_q     <= sync1_q;
      aclk_prev_q <= sync2_q[52];
    end
  end

  wire        s_aclk   = sync2_q[52];
  wire        s_sel    = sync2_q[51];
  wire        s_wr     = sync2_q[50];
  wire        s_rd     = sync2_q[49];
  wire [1:0]  s_adr    = sync2_q[48:47];
  wire [3:0]  s_be     = sync2_q[46:43];
  wire [31:0] s_dq     = sync2_q[42:11];
  wire        s_load_n = sync2_q[10];
  wire [7:0]  s_port   = sync2_q[9:2];
  wire        s_dir    = sync2_q[1];
  wire        s_wide16 = sync2_q[0];

  wire a_edge = s_aclk & ~aclk_prev_q;
  wire a_wr   = a_edge & s_sel & s_wr;
  wire a_rd   = a_edge & s_sel & s_rd & ~s_wr;
  wire a_load = a_edge & ~s_load_n; // RULE6

  // 16-bit bus: byte enable 3 steers the low pair onto the upper half
  wire [3:0]  be_hi  = {s_be[1:0], 2'b00};
  wire [3:0]  be_lo  = {2'b00, s_be[1:0]};
  wire [3:0]  be16   = s_be[3] ? be_hi : be_lo; // RULE22
  wire [3:0]  a_be   = s_wide16 ? be16 : s_be; // RULE22
  // 16-bit data arrives on the low half and is mirrored to both halves
  wire [31:0] dq_dup = {s_dq[15:0], s_dq[15:0]};
  wire [31:0] a_din  = s_wide16 ? dq_dup : s_dq; // RULE22

  // classic wishbone: one data phase per cycle, no burst continuation
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O; // RULE12
  wire wb_wr  = wb_req & WB_WE_I;
  wire wb_rd  = wb_req & ~WB_WE_I;

  wire [1:0] p_out_sel = pci_int_ctrl_status_q[`MIBP_P_OUT_SEL_LO +: 2];
  wire [1:0] p_in_sel  = pci_int_ctrl_status_q[`MIBP_P_IN_SEL_LO +: 2];
  wire [1:0] a_out_sel = addon_int_ctrl_status_q[`MIBP_A_OUT_SEL_LO +: 2];
  wire [1:0] a_in_sel  = addon_int_ctrl_status_q[`MIBP_A_IN_SEL_LO +: 2];

  // pci-side register strobes
  wire wb_at_out  = wb_wr & (WB_ADR_I == `MIBP_ADR_PCI_OUT_MBOX);
  wire wb_at_in   = wb_rd & (WB_ADR_I == `MIBP_ADR_PCI_IN_MBOX);
  wire wb_at_ctrl = wb_wr & (WB_ADR_I == `MIBP_ADR_PCI_INT_CTRL);
  wire wb_at_rst  = wb_wr & (WB_ADR_I == `MIBP_ADR_PCI_RESET_CTRL);

  // add-on register strobes
  wire a_at_out   = a_wr & (s_adr == `MIBP_AADR_OUT_MBOX);
  wire a_at_in    = a_rd & (s_adr == `MIBP_AADR_IN_MBOX);
  wire a_at_flags = a_wr & (s_adr == `MIBP_AADR_FLAGS);
  wire a_at_ctrl  = a_wr & (s_adr == `MIBP_AADR_INT_CTRL);

  // global flag reset from either side, write one only
  wire flag_reset = (wb_at_rst & WB_SEL_I[0] & WB_DAT_I[`MIBP_FLAG_RESET_BIT]) |
                    (a_at_flags & a_be[0] & a_din[`MIBP_FLAG_RESET_BIT]);

  // write-one clears of the sticky sources, lane 2 only
  wire p_in_clr   = wb_at_ctrl & WB_SEL_I[2] & WB_DAT_I[`MIBP_P_IN_IND];
  wire p_out_clr  = wb_at_ctrl & WB_SEL_I[2] & WB_DAT_I[`MIBP_P_OUT_IND];
  wire a_in_clr   = a_at_ctrl & a_be[2] & a_din[`MIBP_A_IN_IND];
  wire a_out_clr  = a_at_ctrl & a_be[2] & a_din[`MIBP_A_OUT_IND];

  // masks kept 32 bits wide so each lane is cut by a part-select
  wire [31:0] p_mask = `MIBP_P_CTRL_MASK;
  wire [31:0] a_mask = `MIBP_A_CTRL_MASK;

  always @* begin
    pci_out_mailbox_d       = pci_out_mailbox_q;
    addon_out_mailbox_d     = addon_out_mailbox_q;
    pout_full_d             = pout_full_q;
    aout_full_d             = aout_full_q;
    pci_int_ctrl_status_d   = pci_int_ctrl_status_q;
    addon_int_ctrl_status_d = addon_int_ctrl_status_q;
    ev_pin  = 1'b0;
    ev_pout = 1'b0;
    ev_ain  = 1'b0;
    ev_aout = 1'b0;

    // clears first, so a set in the same cycle wins
    if (flag_reset) begin
      pout_full_d = `MIBP_RST_FLAGS;
      aout_full_d = `MIBP_RST_FLAGS;
    end
    if (a_at_in) begin
      pout_full_d = pout_full_d & ~a_be; // RULE23
      ev_pout = pci_int_ctrl_status_q[`MIBP_P_OUT_EN] & a_be[p_out_sel] & pout_full_q[p_out_sel]; // RULE2 RULE24
    end
    if (wb_at_in) begin
      aout_full_d = aout_full_d & ~WB_SEL_I; // RULE23
      ev_aout = addon_int_ctrl_status_q[`MIBP_A_OUT_EN] & WB_SEL_I[a_out_sel] & aout_full_q[a_out_sel]; // RULE2
    end

    // outgoing writes overwrite even when full, no error
    if (wb_at_out) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (WB_SEL_I[i]) begin
          pci_out_mailbox_d[i*8 +: 8] = WB_DAT_I[i*8 +: 8]; // RULE13
        end
      end
      pout_full_d = pout_full_d | WB_SEL_I; // RULE23
      ev_ain = addon_int_ctrl_status_q[`MIBP_A_IN_EN] & WB_SEL_I[a_in_sel]; // RULE1 RULE3
    end
    if (a_at_out) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (a_be[i]) begin
          addon_out_mailbox_d[i*8 +: 8] = a_din[i*8 +: 8]; // RULE13 RULE21
        end
      end
      aout_full_d = aout_full_d | a_be; // RULE23
      ev_pin = pci_int_ctrl_status_q[`MIBP_P_IN_EN] & a_be[p_in_sel]; // RULE1 RULE25
    end
    // port capture after the register write: same-edge collision keeps the port value
    if (a_load) begin
      addon_out_mailbox_d[31:24] = s_port; // RULE4 RULE8
      aout_full_d[3] = 1'b1;
      ev_pin = ev_pin | (pci_int_ctrl_status_q[`MIBP_P_IN_EN] & (p_in_sel == 2'd3)); // RULE7
    end

    if (wb_at_ctrl) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (WB_SEL_I[i]) begin
          pci_int_ctrl_status_d[i*8 +: 8] = WB_DAT_I[i*8 +: 8] & p_mask[i*8 +: 8]; // RULE3
        end
      end
    end
    if (a_at_ctrl) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (a_be[i]) begin
          addon_int_ctrl_status_d[i*8 +: 8] = a_din[i*8 +: 8] & a_mask[i*8 +: 8]; // RULE3
        end
      end
    end

    // sticky sources, write one to clear, new event wins
    pin_int_d  = (pin_int_q & ~p_in_clr) | ev_pin;
    pout_int_d = (pout_int_q & ~p_out_clr) | ev_pout;
    ain_int_d  = (ain_int_q & ~a_in_clr) | ev_ain;
    aout_int_d = (aout_int_q & ~a_out_clr) | ev_aout;
  end

  // stale data is returned on empty reads; flags are software's guard
  always @* begin
    wb_rdata = `MIBP_RST_WORD;
    case (WB_ADR_I)
      `MIBP_ADR_PCI_OUT_MBOX: wb_rdata = pci_out_mailbox_q;
      `MIBP_ADR_PCI_IN_MBOX:  wb_rdata = addon_out_mailbox_q; // RULE14
      `MIBP_ADR_PCI_FLAGS: begin
        wb_rdata[`MIBP_P_FLAG_OUT_LO +: 4] = pout_full_q;
        wb_rdata[`MIBP_P_FLAG_IN_LO +: 4]  = aout_full_q;
      end
      `MIBP_ADR_PCI_INT_CTRL: begin
        wb_rdata = pci_int_ctrl_status_q;
        wb_rdata[`MIBP_P_OUT_IND]  = pout_int_q;
        wb_rdata[`MIBP_P_IN_IND]   = pin_int_q;
        wb_rdata[`MIBP_P_ASSERTED] = ~INTA_N;
      end
      default: wb_rdata = `MIBP_RST_WORD;
    endcase
  end

  always @* begin
    a_rdata = `MIBP_RST_WORD;
    case (s_adr)
      `MIBP_AADR_OUT_MBOX: a_rdata = addon_out_mailbox_q;
      `MIBP_AADR_IN_MBOX:  a_rdata = pci_out_mailbox_q; // RULE14
      `MIBP_AADR_FLAGS: begin
        a_rdata[`MIBP_A_FLAG_IN_LO +: 4]  = pout_full_q;
        a_rdata[`MIBP_A_FLAG_OUT_LO +: 4] = aout_full_q;
      end
      `MIBP_AADR_INT_CTRL: begin
        a_rdata = addon_int_ctrl_status_q;
        a_rdata[`MIBP_A_IN_IND]  = ain_int_q;
        a_rdata[`MIBP_A_OUT_IND] = aout_int_q;
      end
      default: a_rdata = `MIBP_RST_WORD;
    endcase
    if (s_wide16) begin
      a_rdata = s_be[3] ? {16'h0000, a_rdata[31:16]} : {16'h0000, a_rdata[15:0]}; // RULE22
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pci_out_mailbox_q       <= `MIBP_RST_WORD;
      addon_out_mailbox_q     <= `MIBP_RST_WORD;
      pout_full_q             <= `MIBP_RST_FLAGS;
      aout_full_q             <= `MIBP_RST_FLAGS;
      pci_int_ctrl_status_q   <= `MIBP_RST_WORD;
      addon_int_ctrl_status_q <= `MIBP_RST_WORD;
      pin_int_q               <= 1'b0;
      pout_int_q              <= 1'b0;
      ain_int_q               <= 1'b0;
      aout_int_q              <= 1'b0;
    end else begin
      pci_out_mailbox_q       <= pci_out_mailbox_d;
      addon_out_mailbox_q     <= addon_out_mailbox_d;
      pout_full_q             <= pout_full_d;
      aout_full_q             <= aout_full_d;
      pci_int_ctrl_status_q   <= pci_int_ctrl_status_d;
      addon_int_ctrl_status_q <= addon_int_ctrl_status_d;
      pin_int_q               <= pin_int_d;
      pout_int_q              <= pout_int_d;
      ain_int_q               <= ain_int_d;
      aout_int_q              <= aout_int_d;
    end
  end

  // wishbone answer: one ack per request, read data held until the next read
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `MIBP_RST_WORD;
    end else begin
      WB_ACK_O <= wb_req; // RULE12
      if (wb_rd) begin
        WB_DAT_O <= wb_rdata;
      end
    end
  end

  // interrupt lines, idle high
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      INTA_N      <= 1'b1;
      ADDON_IRQ_N <= 1'b1;
    end else begin
      // event asserts at once; clear shows one clock after the source drops
      INTA_N <= ~(pin_int_q | pout_int_q | ev_pin | ev_pout); // RULE15 RULE16 RULE17
      // single domain: each crossing event is one pulse, latched in one sticky bit
      if (a_edge) begin
        ADDON_IRQ_N <= ~(ain_int_q | aout_int_q); // RULE18 RULE19 RULE20 RULE26
      end
    end
  end

  // add-on read data and byte port
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ADDON_DQ_OUT           <= `MIBP_RST_WORD;
      MAILBOX_BYTE_PORT_OUT  <= 8'h00;
      MAILBOX_BYTE_PORT_OE_N <= 1'b1;
    end else begin
      if (a_rd) begin
        ADDON_DQ_OUT <= a_rdata;
      end
      MAILBOX_BYTE_PORT_OUT  <= pci_out_mailbox_q[31:24]; // RULE9
      // relies on the far party's turnaround before it drives the port
      MAILBOX_BYTE_PORT_OE_N <= s_dir | ~s_load_n; // RULE5 RULE10 RULE11
    end
  end

endmodule

// ==== hw/mibp_defines.vh ====
// register map, field positions and reset values of the mailbox interrupt block
`ifndef MIBP_DEFINES_VH
`define MIBP_DEFINES_VH

// wishbone byte addresses, pci-side view
`define MIBP_ADR_PCI_OUT_MBOX   8'h00
`define MIBP_ADR_PCI_IN_MBOX    8'h04
`define MIBP_ADR_PCI_FLAGS      8'h08
`define MIBP_ADR_PCI_INT_CTRL   8'h0C
`define MIBP_ADR_PCI_RESET_CTRL 8'h10

// add-on register select codes
`define MIBP_AADR_OUT_MBOX      2'h0
`define MIBP_AADR_IN_MBOX       2'h1
`define MIBP_AADR_FLAGS         2'h2
`define MIBP_AADR_INT_CTRL      2'h3

// pci interrupt control/status fields
`define MIBP_P_OUT_SEL_LO       0
`define MIBP_P_OUT_EN           4
`define MIBP_P_IN_SEL_LO        8
`define MIBP_P_IN_EN            12
`define MIBP_P_OUT_IND          16
`define MIBP_P_IN_IND           17
`define MIBP_P_ASSERTED         23
`define MIBP_P_CTRL_MASK        32'h0000_1313

// add-on interrupt control/status fields
`define MIBP_A_IN_SEL_LO        0
`define MIBP_A_IN_EN            4
`define MIBP_A_OUT_SEL_LO       8
`define MIBP_A_OUT_EN           12
`define MIBP_A_IN_IND           16
`define MIBP_A_OUT_IND          17
`define MIBP_A_CTRL_MASK        32'h0000_1313

// flag register layout (pci view: in = add-on outgoing, out = pci outgoing)
`define MIBP_P_FLAG_OUT_LO      12
`define MIBP_P_FLAG_IN_LO       28
`define MIBP_A_FLAG_IN_LO       12
`define MIBP_A_FLAG_OUT_LO      28

// write-one flag reset bit in the pci reset control word and the add-on flags word
`define MIBP_FLAG_RESET_BIT     0

`define MIBP_RST_WORD           32'h0000_0000
`define MIBP_RST_FLAGS          4'h0

`endif
